// file: rtl/wdt_cfg.svh
// Constants for the watchdog timer unit: offsets, fields, reset values and timing.
// Notes on behaviour
// RULE1: Sixteen-bit up-counter advancing on 32.768 kHz ticks, independent of core clock; here a fractional divider makes the ticks from the core clock.
// RULE2: Enable bit low keeps the watchdog idle, no reset, no interrupt.
// RULE3: Writing one to enable restarts the count; missing refresh triggers timeout.
// RULE4: Timeout gives system reset if action select is zero, else interrupt.
// RULE5: Enable clears on a zero write or on a watchdog reset.
// RULE6: Codes 0 to 7 time out after 512 times two-to-the-code ticks.
// RULE7: Timeout sets status flag; a watchdog reset leaves it intact.
// RULE8: Control writes are ignored unless unlock was set just before.
// RULE9: Control register at C0H, bit-addressable, power-on value 10H.
// RULE10: Prescale code eight forces immediate reset; higher codes are reserved.
// RULE11: Unlock lasts for the very next write only.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

`define WDT_CTRL_ADDR 8'hC0
`define WDT_CTRL_BIT_BASE 8'hC0
`define WDT_CTRL_RESET 8'h10
`define WDT_PRE_MSB 7
`define WDT_PRE_LSB 4
`define WDT_ACT_BIT 3
`define WDT_STAT_BIT 2
`define WDT_EN_BIT 1
`define WDT_UNLOCK_BIT 0
`define WDT_PRE_IMMEDIATE 4'h8
`define WDT_BASE_TICKS 16'h0200
`define WDT_CLK_HZ 125000000
`define WDT_LF_HZ 32768
`define WDT_RST_HOLD 8

`endif

// file: rtl/wdt_pkg.sv
// Types shared by the watchdog timer unit.
package wdt_pkg;
	typedef enum logic [0:0] {
		WDT_RUN = 1'b0,
		WDT_HOLD = 1'b1
	} wdt_rst_e;

	typedef struct packed {
		logic [3:0] prescale;
		logic action_select;
		logic status;
		logic enable;
		logic unlock;
	} wdt_ctrl_s;
endpackage

// file: rtl/wdt_cnt_if.sv
// Carrier between the watchdog control logic and its tick counter.
`timescale 1ns/1ns
interface wdt_cnt_if;
	logic tick;
	logic run;
	logic restart;
	logic [2:0] prescale;
	logic timeout;

	modport ctl (output tick, output run, output restart, output prescale, input timeout);
	modport cnt (input tick, input run, input restart, input prescale, output timeout);
endinterface

// file: rtl/wdt_counter.sv
// Sixteen-bit low-frequency tick counter with programmable terminal count.
`timescale 1ns/1ns
module wdt_counter
	import wdt_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst_sync_n,
	wdt_cnt_if.cnt bus
);
	`include "wdt_cfg.svh"

	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic [CNT_W-1:0] last_tick;
	logic timeout_q;
	logic timeout_d;

	// Terminal value wraps to all ones at the top code, so no extra bit
	assign last_tick = CNT_W'((`WDT_BASE_TICKS << bus.prescale) - 16'h0001); // RULE6

	// Count ticks only while running; restart or idle holds at zero
	always_comb begin
		count_d = count_q;
		timeout_d = 1'b0;
		if (!bus.run || bus.restart) begin // RULE2
			count_d = '0; // RULE3
		end else if (bus.tick) begin
			if (count_q == last_tick) begin
				count_d = '0;
				timeout_d = 1'b1; // RULE3
			end else begin
				count_d = count_q + 1'b1; // RULE1
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			count_q <= '0;
			timeout_q <= 1'b0;
		end else begin
			count_q <= count_d;
			timeout_q <= timeout_d;
		end
	end

	assign bus.timeout = timeout_q;
endmodule

// file: rtl/wdt_top.sv
// Watchdog timer unit: control register, tick divider, timeout actions.
`timescale 1ns/1ns
`include "wdt_cfg.svh"

module wdt_top
	import wdt_pkg::*;
#(
	parameter int CLK_HZ = `WDT_CLK_HZ,
	parameter int LF_HZ = `WDT_LF_HZ,
	parameter int RST_HOLD = `WDT_RST_HOLD
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic [7:0] bit_addr,
	input wire logic bit_wr,
	input wire logic bit_wdata,
	output logic sys_reset_req,
	output logic wdt_irq
);
	// Accumulator wide enough for the core rate plus one step, no overflow

	localparam int ACC_W = 28;
	localparam int HOLD_W = 8;

	logic rst_meta_q;
	logic rst_sync_n;
	wdt_cnt_if cnt_bus ();

	wdt_ctrl_s ctrl_q;
	wdt_ctrl_s ctrl_d;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] acc_d;
	logic [ACC_W-1:0] acc_sum;
	logic tick_q;
	logic tick_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	wdt_rst_e rst_st_q;
	wdt_rst_e rst_st_d;
	logic [HOLD_W-1:0] hold_q;
	logic [HOLD_W-1:0] hold_d;
	logic irq_q;
	logic irq_d;

	logic byte_hit;
	logic bit_hit;
	logic [2:0] bit_sel;
	logic any_wr;
	logic arm;
	logic accept;
	logic [7:0] cur;
	logic [7:0] wval;
	logic refresh;
	logic immediate;
	logic reserved;
	logic fire;
	logic fire_reset;

	// Reset release through two flops; only the second feeds the design
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// Fractional divider: exact 32.768 kHz average, jitter of one core cycle
	assign acc_sum = acc_q + ACC_W'(LF_HZ);
	always_comb begin
		acc_d = acc_sum;
		tick_d = 1'b0;
		if (acc_sum >= ACC_W'(CLK_HZ)) begin
			acc_d = acc_sum - ACC_W'(CLK_HZ);
			tick_d = 1'b1; // RULE1
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			acc_q <= '0;
			tick_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			tick_q <= tick_d;
		end
	end

	// Register access decode, byte and bit forms
	assign byte_hit = sfr_wr && (sfr_addr == `WDT_CTRL_ADDR); // RULE9
	assign bit_hit = bit_wr && (bit_addr[7:3] == 5'(`WDT_CTRL_BIT_BASE >> 3)); // RULE9
	assign bit_sel = bit_addr[2:0];
	assign any_wr = sfr_wr || bit_wr;
	assign cur = ctrl_q;

	// Merged write value for a byte or single-bit write
	always_comb begin
		wval = cur;
		if (byte_hit) begin
			wval = sfr_wdata;
		end else if (bit_hit) begin
			wval[bit_sel] = bit_wdata;
		end
	end

	// Locked: only setting the unlock bit is taken; unlocked: one write lands
	assign arm = !ctrl_q.unlock && (byte_hit || bit_hit) && wval[`WDT_UNLOCK_BIT]; // RULE8
	assign accept = ctrl_q.unlock && (byte_hit || bit_hit); // RULE8
	assign refresh = accept && wval[`WDT_EN_BIT]; // RULE3

	assign immediate = ctrl_q.enable && (ctrl_q.prescale == `WDT_PRE_IMMEDIATE); // RULE10
	assign reserved = ctrl_q.prescale > `WDT_PRE_IMMEDIATE;
	assign fire = ctrl_q.enable && !ctrl_q.prescale[3] && cnt_bus.timeout; // RULE2
	assign fire_reset = immediate || (fire && !ctrl_q.action_select); // RULE4

	// Control register next state; hardware sets win over software clears
	always_comb begin
		ctrl_d = ctrl_q;
		if (accept) begin
			ctrl_d = wval;
			ctrl_d.unlock = 1'b0; // RULE11
		end else if (arm) begin
			ctrl_d.unlock = 1'b1; // RULE8
		end else if (any_wr) begin
			ctrl_d.unlock = 1'b0; // RULE11
		end
		if (fire || immediate) begin
			ctrl_d.status = 1'b1; // RULE7
		end
		if (fire_reset) begin
			ctrl_d.enable = 1'b0; // RULE5
		end
	end

	// Only power-on reset reloads the register, so status survives a watchdog reset
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ctrl_q <= `WDT_CTRL_RESET; // RULE9
		end else begin
			ctrl_q <= ctrl_d; // RULE7
		end
	end

	// Counter steering
	assign cnt_bus.tick = tick_q;
	assign cnt_bus.run = ctrl_q.enable && !ctrl_q.prescale[3] && !reserved; // RULE2
	assign cnt_bus.restart = refresh; // RULE3
	assign cnt_bus.prescale = ctrl_q.prescale[2:0]; // RULE6

	wdt_counter #(
		.CNT_W(16)
	) u_counter (
		.clk(clk),
		.rst_sync_n(rst_sync_n),
		.bus(cnt_bus)
	);

	// Reset request stretched so the reset generator sees a clean pulse
	always_comb begin
		rst_st_d = rst_st_q;
		hold_d = hold_q;
		irq_d = fire && ctrl_q.action_select; // RULE4
		case (rst_st_q)
			WDT_RUN: begin
				if (fire_reset) begin
					rst_st_d = WDT_HOLD; // RULE4
					hold_d = HOLD_W'(RST_HOLD - 1);
				end
			end
			WDT_HOLD: begin
				if (hold_q == '0) begin
					rst_st_d = WDT_RUN;
				end else begin
					hold_d = hold_q - 1'b1;
				end
			end
			default: begin
				rst_st_d = WDT_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rst_st_q <= WDT_RUN;
			hold_q <= '0;
			irq_q <= 1'b0;
		end else begin
			rst_st_q <= rst_st_d;
			hold_q <= hold_d;
			irq_q <= irq_d;
		end
	end

	// Registered read data; unmapped addresses read zero
	always_comb begin
		rdata_d = rdata_q;
		if (sfr_rd) begin
			rdata_d = (sfr_addr == `WDT_CTRL_ADDR) ? cur : 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign sys_reset_req = (rst_st_q == WDT_HOLD);
	assign wdt_irq = irq_q;
endmodule

// file: test/wdt_chk.sv
// Port checker for the watchdog timer unit.
`timescale 1ns/1ns
module wdt_chk #(
	parameter int RST_HOLD = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic [7:0] bit_addr,
	input wire logic bit_wr,
	input wire logic bit_wdata,
	input wire logic sys_reset_req,
	input wire logic wdt_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Cycles of reset request seen so far in the current pulse
	logic [15:0] rst_len_q;
	always_ff @(posedge clk) begin
		rst_len_q <= sys_reset_req ? rst_len_q + 16'h0001 : 16'h0000;
	end
	reset_cap_a: assert property (rst_len_q <= 16'(RST_HOLD))
		else $error("reset too long");
	// Unlock by bit write, data byte on the very next edge
	sequence ctl_wr_s;
		(bit_wr && bit_addr == 8'hC0 && bit_wdata) ##1 (sfr_wr && sfr_addr == 8'hC0);
	endsequence
	// Hold figure fixed at 8, matching the bench's RST_HOLD
	one_action_a: assert property (!(wdt_irq && sys_reset_req))
		else $error("both actions");
	irq_pulse_a: assert property (wdt_irq |=> !wdt_irq)
		else $error("irq long");
	reset_hold_a: assert property ($rose(sys_reset_req) |-> sys_reset_req[*8] ##1 !sys_reset_req)
		else $error("reset length");
	unmapped_rd_a: assert property (sfr_rd && sfr_addr != 8'hC0 |=> sfr_rdata == 8'h00)
		else $error("unmapped read");
	rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("rdata moved");
	write_back_a: assert property (ctl_wr_s ##1 (sfr_rd && sfr_addr == 8'hC0)
		|=> sfr_rdata == ($past(sfr_wdata, 2) & 8'hFE)) else $error("write lost");
	immed_rst_a: assert property (ctl_wr_s ##0 sfr_wdata == 8'h82 |=> ##[0:2] sys_reset_req)
		else $error("no immediate reset");
	off_quiet_a: assert property (ctl_wr_s ##0 !sfr_wdata[1] |=> (!wdt_irq) [*8])
		else $error("irq while off");
	refresh_a: assert property (ctl_wr_s ##0 sfr_wdata[1] && sfr_wdata[7:4] < 4'h8
		|=> (!wdt_irq && !sys_reset_req) [*8]) else $error("action after refresh");
endmodule
bind wdt_top wdt_chk #(.RST_HOLD(RST_HOLD)) wdt_chk_inst (.clk(clk), .rst_n(rst_n),
	.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
	.sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata),
	.sys_reset_req(sys_reset_req), .wdt_irq(wdt_irq));

// file: test/wdt_top_bench.sv
// Self-checking bench for the watchdog timer unit.
`timescale 1ns/1ns
module wdt_top_bench;
	logic clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wdata = 1;
	logic [7:0] sfr_addr = 8'hC0, sfr_wdata = 8'h00, bit_addr = 8'hC0, sfr_rdata;
	logic sys_reset_req, wdt_irq;
	int n_errors = 0, check_count = 0;
	// Rows: address, byte after unlock, expected read-back
	logic [7:0] rows [5][3] = '{'{8'hC0, 8'h70, 8'h70}, '{8'hC0, 8'h39, 8'h38},
		'{8'hC0, 8'hF4, 8'hF4}, '{8'hC1, 8'h55, 8'h00}, '{8'hC0, 8'h00, 8'h00}};
	always #4 clk = ~clk;
	// Fast tick: one per 10 core cycles
	wdt_top #(.LF_HZ(12500000), .RST_HOLD(8)) wdt_top_inst (.clk(clk), .rst_n(rst_n),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wdata(bit_wdata),
		.sys_reset_req(sys_reset_req), .wdt_irq(wdt_irq));
	task conclude;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] exp, got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Tasks start at a falling edge and end on one
	task wr(input logic [7:0] a, d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		@(negedge clk);
		sfr_wr = 0;
	endtask
	task uwr(input logic [7:0] a, d);
		bit_wr = 1;
		@(negedge clk);
		bit_wr = 0;
		wr(a, d);
	endtask
	task rd(input logic [7:0] a, exp, input string what);
		sfr_addr = a;
		sfr_rd = 1;
		@(negedge clk);
		sfr_rd = 0;
		chk(what, exp, sfr_rdata);
	endtask
	// Equal bounds mean the action must not come within hi cycles
	task waitev(input logic for_rst, input int lo, hi);
		int n;
		n = 0;
		while (n < hi && (for_rst ? sys_reset_req : wdt_irq) !== 1'b1) begin
			@(negedge clk);
			n++;
		end
		check_count++;
		if (n < lo || (n == hi && lo < hi)) begin
			n_errors++;
			$display("[ERR] action wait expected %0d..%0d seen %0d", lo, hi, n);
		end
		if (n == hi && lo < hi) conclude();
	endtask
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
		rd(8'hC0, 8'h10, "reset value");
		foreach (rows[i]) begin
			uwr(rows[i][0], rows[i][1]);
			rd(rows[i][0], rows[i][2], "row read");
		end
		uwr(8'hC1, 8'h00);
		@(negedge clk);
		wr(8'hC0, 8'h02);
		rd(8'hC0, 8'h00, "locked write");
		uwr(8'hC0, 8'h0A);
		repeat (4000) @(negedge clk);
		uwr(8'hC0, 8'h0A);
		waitev(0, 5100, 5150);
		rd(8'hC0, 8'h0E, "irq status");
		waitev(0, 5090, 5150);
		uwr(8'hC0, 8'h00);
		waitev(0, 6000, 6000);
		uwr(8'hC0, 8'h12);
		waitev(1, 10220, 10270);
		repeat (10) @(negedge clk);
		rd(8'hC0, 8'h14, "reset status");
		uwr(8'hC0, 8'h82);
		waitev(1, 0, 4);
		repeat (10) @(negedge clk);
		rd(8'hC0, 8'h84, "immediate status");
		// Bit form: unlock bit, then action select bit on the next edge
		bit_wr = 1;
		@(negedge clk);
		bit_addr = 8'hC3;
		@(negedge clk);
		bit_wr = 0;
		bit_addr = 8'hC0;
		rd(8'hC0, 8'h8C, "bit write");
		// Locked bit write to enable must not land, or an immediate reset follows
		bit_addr = 8'hC1;
		bit_wr = 1;
		@(negedge clk);
		bit_wr = 0;
		bit_addr = 8'hC0;
		rd(8'hC0, 8'h8C, "locked bit write");
		// Second power-on reset reloads the register and drops status
		rst_n = 0;
		repeat (2) @(negedge clk);
		chk("rdata in reset", 8'h00, sfr_rdata);
		rst_n = 1;
		repeat (3) @(negedge clk);
		rd(8'hC0, 8'h10, "reset again");
		conclude();
	end
endmodule
